//--- rtl/mixed_width_dual_clock_fifo.sv
/*
 Dual-clock buffer with independent write and read widths.
 Write side runs on clock, read side on read_clock; nrst resets both,
 released into the read domain through its own synchroniser.
 Assumes write_request and read_request come from logic on their own clocks.
*/
`default_nettype none

module mixed_width_dual_clock_fifo #(
    parameter int WRITE_WIDTH = mwfifo_pkg::DEFAULT_WRITE_WIDTH,
    parameter int READ_WIDTH = mwfifo_pkg::DEFAULT_READ_WIDTH,
    parameter int DEPTH_LOG = mwfifo_pkg::DEFAULT_DEPTH_LOG,
    localparam int NW = (WRITE_WIDTH < READ_WIDTH) ? WRITE_WIDTH : READ_WIDTH,
    localparam int WR = WRITE_WIDTH / NW,
    localparam int RR = READ_WIDTH / NW,
    localparam int WSH = $clog2(WR),
    localparam int RSH = $clog2(RR),
    localparam int WPW = DEPTH_LOG - WSH + 1,
    localparam int RPW = DEPTH_LOG - RSH + 1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic write_request,
    input wire logic [WRITE_WIDTH-1:0] write_data,
    output logic write_full,
    output logic write_empty,
    output logic [WPW-1:0] write_used,
    input wire logic read_clock,
    input wire logic read_request,
    output logic [READ_WIDTH-1:0] read_data,
    output logic read_empty,
    output logic read_full,
    output logic [RPW-1:0] read_used
);
    localparam int NPW = DEPTH_LOG + 1;
    localparam int NDEPTH = 1 << DEPTH_LOG;
    localparam logic [NPW-1:0] NDEPTH_N = NPW'(NDEPTH);
    localparam logic [NPW-1:0] WR_N = NPW'(WR);
    localparam logic [NPW-1:0] RR_N = NPW'(RR);
    localparam logic [RPW-1:0] READ_CAP = RPW'(NDEPTH >> RSH);
    localparam int LARGE = (WR > RR) ? WR : RR;
    localparam int RATIO_LOG = mwfifo_pkg::exact_log2(LARGE);

    // Rejected widths stop elaboration rather than build a broken buffer
    generate
        if ((WRITE_WIDTH % NW) != 0 || (READ_WIDTH % NW) != 0 || RATIO_LOG < 0 ||
            RATIO_LOG > mwfifo_pkg::MAX_RATIO_LOG || RATIO_LOG >= DEPTH_LOG) begin : bad_ratio
            $error("unsupported write/read width ratio"); // R01
        end
    endgenerate

    // Storage in narrow slots; either port may be wide
    logic [NW-1:0] mem [NDEPTH]; // R02

    // Write domain
    logic [WPW-1:0] wptr;
    logic [WPW-1:0] wgray;
    logic [NPW-1:0] wptr_n;
    logic [NPW-1:0] rsync_n;
    logic [NPW-1:0] wused_n;
    logic [NPW-1:0] room_n;
    logic [DEPTH_LOG-1:0] waddr_n;
    logic [DEPTH_LOG-1:0] waddr_top;
    logic write_accept;

    ptr_xfer_if #(.WIDTH(RPW)) rd_xfer ();
    ptr_xfer_if #(.WIDTH(WPW)) wr_xfer ();

    assign wptr_n = NPW'(NPW'(wptr) << WSH);
    assign rsync_n = NPW'(NPW'(RPW'(mwfifo_pkg::from_gray(32'(rd_xfer.dst_gray)))) << RSH);
    assign wused_n = wptr_n - rsync_n;
    assign room_n = NDEPTH_N - wused_n;
    assign waddr_n = wptr_n[DEPTH_LOG-1:0];
    assign waddr_top = DEPTH_LOG'(waddr_n + DEPTH_LOG'(WR - 1));

    // Full as soon as one write word no longer fits
    assign write_full = room_n < WR_N; // R11
    assign write_empty = wused_n == '0;
    assign write_used = WPW'(wused_n >> WSH); // R03 R05
    assign write_accept = write_request && !write_full; // R11

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wptr <= '0;
            wgray <= '0;
        end else if (write_accept) begin
            wptr <= WPW'(wptr + 1'b1); // R03 R05
            wgray <= WPW'(mwfifo_pkg::to_gray(32'(WPW'(wptr + 1'b1)))); // R10
        end
    end

    // Slot 0 of a wide write takes the least-significant slice
    always_ff @(posedge clock) begin
        if (write_accept) begin
            for (int i = 0; i < WR; i++) begin
                mem[DEPTH_LOG'(waddr_n + DEPTH_LOG'(i))] <= write_data[i*NW +: NW]; // R04 R06
            end
        end
    end

    assign wr_xfer.src_gray = wgray; // R08

    gray_ptr_sync #(.WIDTH(RPW)) write_side_pointer_sync (
        .clock(clock),
        .nrst(nrst),
        .link(rd_xfer)
    );

    // Read domain reset: asserted at once, released on read_clock
    logic rd_nrst_meta;
    logic rd_nrst;

    always_ff @(posedge read_clock or negedge nrst) begin
        if (!nrst) begin
            rd_nrst_meta <= mwfifo_pkg::RESET_HELD;
            rd_nrst <= mwfifo_pkg::RESET_HELD;
        end else begin
            rd_nrst_meta <= mwfifo_pkg::RESET_RELEASED;
            rd_nrst <= rd_nrst_meta;
        end
    end

    logic [RPW-1:0] rptr;
    logic [RPW-1:0] rgray;
    logic [NPW-1:0] rptr_n;
    logic [NPW-1:0] wsync_n;
    logic [NPW-1:0] rused_n;
    logic [DEPTH_LOG-1:0] raddr_n;
    logic [DEPTH_LOG-1:0] raddr_top;
    logic [READ_WIDTH-1:0] read_word;
    logic read_accept;

    assign rptr_n = NPW'(NPW'(rptr) << RSH);
    assign wsync_n = NPW'(NPW'(WPW'(mwfifo_pkg::from_gray(32'(wr_xfer.dst_gray)))) << WSH);
    assign rused_n = wsync_n - rptr_n;
    assign raddr_n = rptr_n[DEPTH_LOG-1:0];
    assign raddr_top = DEPTH_LOG'(raddr_n + DEPTH_LOG'(RR - 1));

    // Partial wide words stay invisible to the reader
    assign read_used = RPW'(rused_n >> RSH); // R03 R05
    assign read_empty = read_used == '0; // R07
    assign read_full = read_used == READ_CAP;
    assign read_accept = read_request && !read_empty;

    // Gather narrow slots, oldest into the low end
    always_comb begin
        read_word = '0;
        for (int i = 0; i < RR; i++) begin
            read_word[i*NW +: NW] = mem[DEPTH_LOG'(raddr_n + DEPTH_LOG'(i))]; // R04 R06
        end
    end

    always_ff @(posedge read_clock or negedge rd_nrst) begin
        if (!rd_nrst) begin
            rptr <= '0;
            rgray <= '0;
        end else if (read_accept) begin
            rptr <= RPW'(rptr + 1'b1); // R03
            rgray <= RPW'(mwfifo_pkg::to_gray(32'(RPW'(rptr + 1'b1)))); // R10
        end
    end

    // Flop storage is only safe to read once empty has dropped
    always_ff @(posedge read_clock or negedge rd_nrst) begin
        if (!rd_nrst) begin
            read_data <= '0;
        end else if (read_accept) begin
            read_data <= read_word; // R09
        end
    end

    assign rd_xfer.src_gray = rgray; // R08

    gray_ptr_sync #(.WIDTH(WPW)) read_side_pointer_sync (
        .clock(read_clock),
        .nrst(rd_nrst),
        .link(wr_xfer)
    );

    // Write-domain checks
    full_hold_a: assert property ( // R11
        @(posedge clock) disable iff (!nrst)
        (write_request && write_full) |=> $stable(wptr) && $stable(wgray))
        else $error("write taken while full");

    room_bound_a: assert property ( // R11
        @(posedge clock) disable iff (!nrst)
        wused_n <= NDEPTH_N)
        else $error("write fill exceeds capacity");

    wr_count_a: assert property ( // R03
        @(posedge clock) disable iff (!nrst)
        (write_accept ##1 $stable(rd_xfer.dst_gray)) |-> write_used == WPW'($past(write_used) + 1'b1))
        else $error("write count did not rise by one");

    slice_store_a: assert property ( // R06
        @(posedge clock) disable iff (!nrst)
        write_accept |=> mem[$past(waddr_n)] == $past(write_data[NW-1:0])
            && mem[$past(waddr_top)] == $past(write_data[WRITE_WIDTH-1 -: NW]))
        else $error("write slices stored out of order");

    // Source register moves one bit, so a mid-change sample is old or new
    wr_gray_step_a: assert property ( // R10
        @(posedge clock) disable iff (!nrst)
        $countones(wgray ^ $past(wgray)) <= 1)
        else $error("write gray pointer moved more than one bit");

    wr_gray_match_a: assert property ( // R10
        @(posedge clock) disable iff (!nrst)
        wgray == WPW'(mwfifo_pkg::to_gray(32'(wptr))))
        else $error("write gray pointer out of step with binary pointer");

    wr_empty_low_a: assert property ( // R03
        @(posedge clock) disable iff (!nrst)
        write_accept |=> !write_empty)
        else $error("write side empty after an accepted write");

    // Only a read-side step can free room
    wr_full_stays_a: assert property ( // R11
        @(posedge clock) disable iff (!nrst)
        (write_full ##1 $stable(rd_xfer.dst_gray)) |-> write_full)
        else $error("full dropped with no read seen");

    wr_used_bound_a: assert property ( // R11
        @(posedge clock) disable iff (!nrst)
        write_used <= WPW'(NDEPTH >> WSH))
        else $error("write count above capacity");

    wr_flags_a: assert property ( // R11
        @(posedge clock) disable iff (!nrst)
        !(write_full && write_empty))
        else $error("write side full and empty at once");

    // Read-domain checks
    rd_advance_a: assert property ( // R03
        @(posedge read_clock) disable iff (!rd_nrst)
        read_accept |=> rptr == RPW'($past(rptr) + 1'b1))
        else $error("read pointer did not advance");

    empty_hold_a: assert property ( // R07
        @(posedge read_clock) disable iff (!rd_nrst)
        (read_request && read_empty) |=> $stable(rptr) && $stable(read_data))
        else $error("read taken while empty");

    empty_wide_a: assert property ( // R07
        @(posedge read_clock) disable iff (!rd_nrst)
        (rused_n < RR_N) |-> read_empty && read_used == '0)
        else $error("empty dropped before a full read word");

    slice_read_a: assert property ( // R04
        @(posedge read_clock) disable iff (!rd_nrst)
        read_accept |=> read_data[NW-1:0] == $past(mem[raddr_n])
            && read_data[READ_WIDTH-1 -: NW] == $past(mem[raddr_top]))
        else $error("read slices returned out of order");

    // A faster writer can move the synced pointer two steps; check single steps only
    rd_fill_a: assert property ( // R05
        @(posedge read_clock) disable iff (!rd_nrst)
        ($countones(wr_xfer.dst_gray ^ $past(wr_xfer.dst_gray)) == 1 && !$past(read_accept))
            |-> NPW'(rused_n - $past(rused_n)) == WR_N)
        else $error("read fill did not rise by one write word");

    // Same one-bit rule for the pointer heading back to the writer
    rd_gray_step_a: assert property ( // R10
        @(posedge read_clock) disable iff (!rd_nrst)
        $countones(rgray ^ $past(rgray)) <= 1)
        else $error("read gray pointer moved more than one bit");

    rd_gray_match_a: assert property ( // R10
        @(posedge read_clock) disable iff (!rd_nrst)
        rgray == RPW'(mwfifo_pkg::to_gray(32'(rptr))))
        else $error("read gray pointer out of step with binary pointer");

    // Reader cannot see a word the writer has not published
    rd_empty_stays_a: assert property ( // R07
        @(posedge read_clock) disable iff (!rd_nrst)
        (read_empty ##1 $stable(wr_xfer.dst_gray)) |-> read_empty)
        else $error("empty dropped with no write seen");

    rd_count_a: assert property ( // R03
        @(posedge read_clock) disable iff (!rd_nrst)
        (read_accept ##1 $stable(wr_xfer.dst_gray)) |-> read_used == RPW'($past(read_used) - 1'b1))
        else $error("read count did not fall by one");

    rd_data_hold_a: assert property ( // R09
        @(posedge read_clock) disable iff (!rd_nrst)
        !read_accept |=> $stable(read_data))
        else $error("read data changed without a read");

    // Reader's view of the fill never runs ahead of the writer's
    full_agree_a: assert property ( // R11
        @(posedge read_clock) disable iff (!rd_nrst)
        read_full |-> write_full && !read_empty)
        else $error("read side full while write side has room");

    rd_bound_a: assert property ( // R03
        @(posedge read_clock) disable iff (!rd_nrst)
        rused_n <= NDEPTH_N)
        else $error("read fill exceeds capacity");
endmodule : mixed_width_dual_clock_fifo

`default_nettype wire

//--- rtl/mwfifo_pkg.sv
/*
 Shared constants and helpers for the mixed-width dual-clock buffer.
 Assumes both clock domains use the same pointer conventions.
// Notes on behaviour
//R01: Width ratio must be a power of two, 1 to 32; else configuration fails.
//R02: Either port may be the wide one.
//R03: Wide write adds one write-side, ratio read-side; empties after ratio reads each.
//R04: Narrow reads of a wide word return least-significant slice first.
//R05: Narrow writes add one each; read count rises per complete wide word.
//R06: Earliest narrow write lands in the least-significant slice of a wide read.
//R07: Read empty holds until a whole wide read word has been written.
//R08: Only gray pointers cross domains, through two-stage synchroniser chains.
//R09: With flip-flop storage, consumer samples data only after empty deasserts.
//R10: Crossing pointers are gray coded, changing one bit per step.
//R11: Full when no room for a write word; writes while full ignored.
*/
`default_nettype none

package mwfifo_pkg;
    localparam int DEFAULT_WRITE_WIDTH = 16;
    localparam int DEFAULT_READ_WIDTH = 8;
    // Depth is counted in narrow words
    localparam int DEFAULT_DEPTH_LOG = 5;
    localparam int MAX_RATIO_LOG = 5;
    localparam logic RESET_RELEASED = 1'b1;
    localparam logic RESET_HELD = 1'b0;

    function automatic logic [31:0] to_gray(logic [31:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    function automatic logic [31:0] from_gray(logic [31:0] g);
        logic [31:0] b;
        b = g;
        for (int i = 1; i < 32; i++) begin
            b = b ^ (g >> i);
        end
        return b;
    endfunction : from_gray

    // Returns log2 for a power of two, otherwise -1
    function automatic int exact_log2(int v);
        int r;
        r = -1;
        for (int i = 0; i < 31; i++) begin
            if (v == (1 << i)) begin
                r = i;
            end
        end
        return r;
    endfunction : exact_log2
endpackage : mwfifo_pkg

`default_nettype wire

//--- rtl/ptr_xfer_if.sv
/*
 Gray pointer carrier between one clock domain and the synchroniser
 chain of the other. Assumes the source updates one bit per step.
*/
`default_nettype none

interface ptr_xfer_if #(parameter int WIDTH = 4);
    logic [WIDTH-1:0] src_gray;
    logic [WIDTH-1:0] dst_gray;
    modport source (output src_gray, input dst_gray);
    modport syncer (input src_gray, output dst_gray);
endinterface : ptr_xfer_if

`default_nettype wire

//--- rtl/gray_ptr_sync.sv
/*
 Two-flop synchroniser for a gray pointer, clocked by the receiving domain.
 Assumes the source pointer is registered and gray coded.
*/
`default_nettype none

module gray_ptr_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic nrst,
    ptr_xfer_if.syncer link
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            stable <= '0;
        end else begin
            meta <= link.src_gray; // R08
            stable <= meta;
        end
    end

    assign link.dst_gray = stable;

    sync_delay_a: assert property ( // R08
        @(posedge clock) disable iff (!nrst)
        ##2 (stable == $past(link.src_gray, 2)))
        else $error("pointer sync delay is not two cycles");
endmodule : gray_ptr_sync

`default_nettype wire

//--- bench/stream_partner.sv
/*
 Producer and consumer model for the mixed-width buffer, one per clock domain.
 Assumes a bench module named mixed_width_dual_clock_fifo_tb with a check task.
*/
`default_nettype none

module stream_partner #(
    parameter int WW = 16,
    parameter int RW = 8
) (
    input wire logic clock,
    input wire logic read_clock,
    input wire logic drain,
    input wire logic write_full,
    output logic write_request,
    output logic [WW-1:0] write_data,
    output logic read_request,
    input wire logic [RW-1:0] read_data,
    input wire logic read_empty
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NW = (WW < RW) ? WW : RW;
    logic [NW-1:0] slices[$];
    logic [RW-1:0] want;
    logic taken;

    initial begin
        write_request = 1'b0;
        write_data = '0;
        read_request = 1'b0;
        taken = 1'b0;
    end

    // Full only changes on a clock rise, so the flag at the fall decides acceptance
    task automatic send(input int n, input int tries, input bit stall);
        while (n > 0 && tries > 0) begin
            @(negedge clock);
            tries--;
            write_request = stall ? 1'($urandom_range(0, 1)) : 1'b1;
            write_data = WW'($urandom);
            if (write_request && !write_full) begin
                for (int i = 0; i < WW / NW; i++) slices.push_back(write_data[i*NW +: NW]);
                n--;
            end
        end
        @(negedge clock);
        write_request = 1'b0;
        write_data = ~write_data;
    endtask : send

    always @(negedge read_clock) begin
        if (taken) begin
            for (int i = 0; i < RW / NW; i++) want[i*NW +: NW] = slices.pop_front();
            mixed_width_dual_clock_fifo_tb.check(32'(read_data), 32'(want));
        end
        read_request = drain && ($urandom_range(0, 3) != 0);
        taken = read_request && !read_empty;
    end
endmodule : stream_partner

`default_nettype wire

//--- bench/mixed_width_dual_clock_fifo_tb.sv
/*
 Bench for the mixed-width buffer: one rig per width arrangement, run in turn.
 Assumes the partner model and the design files are compiled first.
*/
`default_nettype none

module fifo_rig #(
    parameter int WW = 16,
    parameter int RW = 8
) (
    input wire logic clock,
    input wire logic read_clock,
    input wire logic nrst
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DL = mwfifo_pkg::DEFAULT_DEPTH_LOG;
    localparam int NW = (WW < RW) ? WW : RW;
    localparam int WR = WW / NW;
    localparam int RR = RW / NW;
    localparam int CAP = (1 << DL) / WR;
    logic drain = 1'b0;
    logic write_request, write_full, write_empty, read_request, read_empty, read_full;
    logic [WW-1:0] write_data;
    logic [RW-1:0] read_data;
    logic [DL-$clog2(WR):0] write_used;
    logic [DL-$clog2(RR):0] read_used;

    mixed_width_dual_clock_fifo #(.WRITE_WIDTH(WW), .READ_WIDTH(RW), .DEPTH_LOG(DL)) u_mixed_width_dual_clock_fifo (
        .clock, .nrst, .write_request, .write_data, .write_full, .write_empty, .write_used,
        .read_clock, .read_request, .read_data, .read_empty, .read_full, .read_used);

    stream_partner #(.WW(WW), .RW(RW)) u_stream_partner (.clock, .read_clock, .drain, .write_full,
        .write_request, .write_data, .read_request, .read_data, .read_empty);

    task automatic settle();
        repeat (8) @(negedge read_clock);
    endtask : settle

    task automatic empty_out();
        drain = 1'b1;
        for (int i = 0; i < 600 && !(read_empty && write_empty); i++) @(negedge read_clock);
        settle();
        mixed_width_dual_clock_fifo_tb.check(32'(read_used), 32'd0);
        mixed_width_dual_clock_fifo_tb.check(32'(u_stream_partner.slices.size()), 32'd0);
        mixed_width_dual_clock_fifo_tb.check(32'(write_empty), 32'd1);
        drain = 1'b0;
    endtask : empty_out

    task automatic run();
        u_stream_partner.send(1, 4, 1'b0);
        settle();
        // A lone narrow word must stay hidden from the wide side
        mixed_width_dual_clock_fifo_tb.check(32'(read_empty), 32'(RR > 1));
        mixed_width_dual_clock_fifo_tb.check(32'(read_used), 32'(WR / RR));
        mixed_width_dual_clock_fifo_tb.check(32'(write_empty), 32'd0);
        u_stream_partner.send(2 * RR - 1, 20, 1'b0);
        settle();
        mixed_width_dual_clock_fifo_tb.check(32'(write_used), 32'(2 * RR));
        mixed_width_dual_clock_fifo_tb.check(32'(read_used), 32'(2 * WR));
        empty_out();
        u_stream_partner.send(CAP + 2, CAP + 6, 1'b0);
        mixed_width_dual_clock_fifo_tb.check(32'(write_full), 32'd1);
        mixed_width_dual_clock_fifo_tb.check(32'(write_used), 32'(CAP));
        settle();
        mixed_width_dual_clock_fifo_tb.check(32'(read_full), 32'd1);
        empty_out();
        drain = 1'b1;
        u_stream_partner.send(60, 600, 1'b1);
        empty_out();
    endtask : run
endmodule : fifo_rig

module mixed_width_dual_clock_fifo_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic read_clock = 1'b0;
    logic nrst = 1'b0;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2.5 clock = ~clock;

    // Offset start keeps the read clock out of step with the main clock
    initial begin
        #1.3;
        forever #3 read_clock = ~read_clock;
    end

    fifo_rig #(.WW(16), .RW(8)) u_rig_down (.clock(clock), .read_clock(read_clock), .nrst(nrst));
    fifo_rig #(.WW(8), .RW(16)) u_rig_up (.clock(clock), .read_clock(read_clock), .nrst(nrst));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(54385));
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge read_clock);
        u_rig_down.run();
        u_rig_up.run();
        end_sim();
    end
endmodule : mixed_width_dual_clock_fifo_tb

`default_nettype wire
